// ==== afe_line_port_consts.vh ====
// Constants for the line-start and pixel data port block
`ifndef AFE_LINE_PORT_CONSTS_VH
`define AFE_LINE_PORT_CONSTS_VH

// Pixel data bus width and phases per conversion
`define BUS_W 6
`define PHASES 4
// Result width, sized for the 12-bit resolution
`define RES_W 12
// Color mode encodings (first color of a line)
`define COLOR_MODE_W 2
`define COLOR_MONO_RED 2'h0
`define COLOR_MONO_GREEN 2'h1
`define COLOR_MONO_BLUE 2'h2
`define COLOR_RGB 2'h3
// Color select codes
`define COLOR_SEL_W 2
`define SEL_RED 2'h0
`define SEL_GREEN 2'h1
`define SEL_BLUE 2'h2
// Serial port pin positions in the low three bus pins
`define SER_DATA_BIT 0
`define SER_CLK_BIT 1
`define SER_SEL_BIT 2

`endif

// ==== afe_line_start_and_data_port.v ====
// Line-start handling, clamp control and pixel data bus driver
// What this block does
// - Strobe high with sample strobe low connects analog inputs to reference.
// - First clock after strobe falls loads first color mux select.
// - Strobe low: drive six data pins with 10- or 12-bit results.
// - Strobe high: data pins released; low three pins form serial port.
// - Each result leaves over four master clock phases, one to three and then the next zero.
`timescale 1ns/1ps
`include "afe_line_port_consts.vh"

module afe_line_start_and_data_port (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rst_n,
	// Line control from the controller
	input wire i_line_start_strobe,
	input wire i_pixel_sample_strobe,
	// Configuration
	input wire i_res12,
	input wire [`COLOR_MODE_W-1:0] i_color_mode,
	// Conversion results, one per sample strobe period
	input wire [`RES_W-1:0] i_conv_data,
	input wire i_conv_valid,
	// Pixel data bus, three signals per pin
	input wire [`BUS_W-1:0] i_pixel_data_bus,
	output reg [`BUS_W-1:0] o_pixel_data_bus,
	output wire [`BUS_W-1:0] o_pixel_data_bus_oe,
	// Analog front end control
	output wire o_clamp_en,
	output reg [`COLOR_SEL_W-1:0] o_color_sel,
	output reg o_color_load,
	// Serial configuration port, gated
	output wire o_ser_data,
	output wire o_ser_clk,
	output wire o_ser_sel,
	output wire o_ser_active,
	// Output phase markers
	output wire o_output_phase_zero,
	output wire o_output_phase_three
);

	localparam [3:0] PH0 = 4'b0001;
	localparam [3:0] PH1 = 4'b0010;
	localparam [3:0] PH2 = 4'b0100;
	localparam [3:0] PH3 = 4'b1000;

	reg line_prev_r;
	reg [3:0] phase_r;
	reg [3:0] phase_nxt;
	reg [`RES_W-1:0] word_r;
	reg [`BUS_W-1:0] bus_nxt;
	reg out_en_r;
	wire line_fall;
	reg ser_data_gated;
	reg ser_clk_gated;
	reg ser_sel_gated;

	// First color chosen by the programmed mode
	function [`COLOR_SEL_W-1:0] first_color;
		input [`COLOR_MODE_W-1:0] mode;
		begin
			case (mode)
				`COLOR_MONO_RED: first_color = `SEL_RED;
				`COLOR_MONO_GREEN: first_color = `SEL_GREEN;
				`COLOR_MONO_BLUE: first_color = `SEL_BLUE;
				// Colour lines always open on red
				`COLOR_RGB: first_color = `SEL_RED;
				default: first_color = `SEL_RED;
			endcase
		end
	endfunction

	// Pick the six pins of a word for one half of a group
	function [`BUS_W-1:0] bus_slice;
		input [`RES_W-1:0] word;
		input res12;
		input low_half;
		begin
			if (res12)
			begin
				if (low_half)
					bus_slice = word[5:0];
				else
					bus_slice = word[11:6];
			end
			else
			begin
				// Short results pad the two bottom pins
				if (low_half)
					bus_slice = {word[3:0], 2'b00};
				else
					bus_slice = word[9:4];
			end
		end
	endfunction

	assign line_fall = line_prev_r & ~i_line_start_strobe;

	assign o_clamp_en = i_line_start_strobe & ~i_pixel_sample_strobe;

	assign o_pixel_data_bus_oe = {`BUS_W{out_en_r & ~i_line_start_strobe}};

	// serial pins gated by strobe
	// Idle at zero so no write can start mid-line
	always @*
	begin
		ser_data_gated = 1'b0;
		ser_clk_gated = 1'b0;
		ser_sel_gated = 1'b0;
		if (i_line_start_strobe)
		begin
			ser_data_gated = i_pixel_data_bus[`SER_DATA_BIT];
			ser_clk_gated = i_pixel_data_bus[`SER_CLK_BIT];
			ser_sel_gated = i_pixel_data_bus[`SER_SEL_BIT];
		end
	end

	assign o_ser_active = i_line_start_strobe;
	assign o_ser_data = ser_data_gated;
	assign o_ser_clk = ser_clk_gated;
	assign o_ser_sel = ser_sel_gated;

	assign o_output_phase_zero = out_en_r & phase_r[0];
	assign o_output_phase_three = out_en_r & phase_r[3];

	always @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			line_prev_r <= 1'b0;
			o_color_sel <= `SEL_RED;
			o_color_load <= 1'b0;
		end
		else
		begin
			line_prev_r <= i_line_start_strobe;
			o_color_load <= line_fall;
			if (line_fall)
				o_color_sel <= first_color(i_color_mode);
		end
	end

	always @*
	begin
		case (phase_r)
			PH0: phase_nxt = PH1;
			PH1: phase_nxt = PH2;
			PH2: phase_nxt = PH3;
			PH3: phase_nxt = PH0;
			default: phase_nxt = PH0;
		endcase
	end

	always @*
	begin
		case (phase_nxt)
			PH0:
			begin
				bus_nxt = bus_slice(word_r, i_res12, 1'b0);
			end
			PH1:
			begin
				bus_nxt = bus_slice(word_r, i_res12, 1'b0);
			end
			PH2:
			begin
				bus_nxt = bus_slice(word_r, i_res12, 1'b1);
			end
			PH3:
			begin
				bus_nxt = bus_slice(word_r, i_res12, 1'b1);
			end
			default:
			begin
				bus_nxt = {`BUS_W{1'b0}};
			end
		endcase
	end

	// result capture per group
	// Taken at the phase-three edge, so phase zero still shows the previous word and phases one to three the new one
	always @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			word_r <= {`RES_W{1'b0}};
		end
		else if (!i_line_start_strobe && i_conv_valid && phase_r[3])
		begin
			word_r <= i_conv_data;
		end
	end

	always @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			phase_r <= PH3;
			out_en_r <= 1'b0;
			o_pixel_data_bus <= {`BUS_W{1'b0}};
		end
		else if (i_line_start_strobe)
		begin
			// Restart so output begins at phase zero and the first new word at phase one
			phase_r <= PH3;
			out_en_r <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			out_en_r <= 1'b1;
			o_pixel_data_bus <= bus_nxt;
		end
	end

endmodule

// ==== afe_chk_assertions.sv ====
// Checker for the line port
`timescale 1ns/1ps
`include "afe_line_port_consts.vh"
module afe_chk (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_line_start_strobe,
	input wire i_pixel_sample_strobe,
	input wire [`BUS_W-1:0] i_pixel_data_bus,
	input wire [`BUS_W-1:0] o_pixel_data_bus_oe,
	input wire o_clamp_en,
	input wire o_color_load,
	input wire o_ser_clk,
	input wire o_output_phase_zero,
	input wire o_output_phase_three
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence grp_s;
		o_output_phase_zero ##0 !i_line_start_strobe [*4];
	endsequence
	clamp_ctl_a: assert property (o_clamp_en == (i_line_start_strobe & !i_pixel_sample_strobe))
		else $error("clamp");
	color_load_a: assert property ($fell(i_line_start_strobe) |=> o_color_load)
		else $error("load");
	bus_drive_a: assert property (!i_line_start_strobe [*2] |-> &o_pixel_data_bus_oe)
		else $error("drive");
	bus_release_a: assert property (i_line_start_strobe |-> o_pixel_data_bus_oe == 6'h0)
		else $error("release");
	phase_order_a: assert property (grp_s |-> o_output_phase_three)
		else $error("phase");
	ser_gate_a: assert property (o_ser_clk == (i_line_start_strobe & i_pixel_data_bus[1]))
		else $error("serial");
endmodule
bind afe_line_start_and_data_port afe_chk afe_chk_i (.*);

// ==== afe_ctl_model.sv ====
// Controller model for the line port
`timescale 1ns/1ps
module afe_ctl_model (
	input wire i_sys_clk,
	input wire [5:0] i_dev_bus,
	input wire i_dev_oe,
	output reg o_strobe = 1'b1,
	output reg o_sample = 1'b0,
	output wire [5:0] o_bus
);
	reg [1:0] div_r = 2'h0;
	always @(posedge i_sys_clk)
	begin
		div_r <= #1 div_r + 2'h1;
		o_sample <= #1 div_r[1];
	end
	assign o_bus = i_dev_oe ? i_dev_bus : {~div_r, ~div_r, div_r};
	task line(input integer n);
	begin
		o_strobe = 1'b1;
		repeat (n) @(posedge i_sys_clk);
		#1 o_strobe = 1'b0;
	end
	endtask
endmodule

// ==== afe_line_start_and_data_port_tb.sv ====
// Testbench for the line port
`timescale 1ns/1ps
module afe_line_start_and_data_port_tb;
	reg clk = 1'b0, rst_n = 1'b0, r12 = 1'b1, cv = 1'b1;
	wire sa, sd, sc, ss, cl;
	reg [1:0] md = 2'h0;
	reg [11:0] wd = 12'h0;
	integer failures = 0, num_checks = 0, m;
	wire stb, smp, ph0, ph3, ld;
	wire [5:0] bus, dbus, oe;
	wire [1:0] sel;
	always #12.5 clk = ~clk;
	afe_ctl_model afe_ctl_model_i (.i_sys_clk(clk), .i_dev_bus(dbus), .i_dev_oe(oe[0]), .o_strobe(stb),
		.o_sample(smp), .o_bus(bus));
	afe_line_start_and_data_port afe_line_start_and_data_port_i (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_line_start_strobe(stb), .i_pixel_sample_strobe(smp), .i_res12(r12), .i_color_mode(md),
		.i_conv_data(wd), .i_conv_valid(cv), .i_pixel_data_bus(bus), .o_pixel_data_bus(dbus),
		.o_pixel_data_bus_oe(oe), .o_clamp_en(cl), .o_color_sel(sel), .o_color_load(ld), .o_ser_data(sd),
		.o_ser_clk(sc), .o_ser_sel(ss), .o_ser_active(sa), .o_output_phase_zero(ph0),
		.o_output_phase_three(ph3));
	task chk(input [31:0] nm, input [5:0] e, input [5:0] g);
	begin
		num_checks = num_checks + 1;
		if (g !== e)
		begin
			failures = failures + 1;
			$display("ERROR %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task finish_test;
	begin
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task line_test(input [1:0] c, input r, input v, input [11:0] w);
		integer p;
	begin
		@(posedge clk);
		#1 md = c;
		r12 = r;
		cv = v;
		if (v)
			wd = w;
		fork
			afe_ctl_model_i.line(4);
			begin
				repeat (2) @(negedge clk);
				chk("ser", {2'h0, 1'b1, bus[2:0]}, {2'h0, sa, ss, sc, sd});
				chk("clmp", {5'h00, ~smp}, {5'h00, cl});
			end
		join
		for (p = 0; p < 9 && ld !== 1'b1; p = p + 1) @(negedge clk);
		chk("ld", 6'h01, {5'h00, ld});
		chk("sel", {4'h0, c == 2'h3 ? 2'h0 : c}, {4'h0, sel});
		chk("ser0", 6'h00, {2'h0, sa, ss, sc, sd});
		chk("clmp", 6'h00, {5'h00, cl});
		repeat (4) @(negedge clk);
		for (p = 0; p < 4; p = p + 1)
		begin
			chk("bus", p < 2 ? (r ? wd[11:6] : wd[9:4]) : (r ? wd[5:0] : {wd[3:0], 2'h0}), dbus);
			chk("ph", {4'h0, p == 0, p == 3}, {4'h0, ph0, ph3});
			@(negedge clk);
		end
	end
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		for (m = 0; m < 4; m = m + 1)
			line_test(m[1:0], m[0], m != 2, {m[1:0], 10'h2c9});
		finish_test;
	end
	initial
	begin
		#20000;
		failures = failures + 1;
		finish_test;
	end
endmodule
